// *** common/aer_regs_pkg.sv ***
// Register map, field layout and carrier types for the error severity and correctable status bank
package aer_regs_pkg;

	// ----------------------------------------
	// Register offsets in extended config space
	// ----------------------------------------
	localparam logic [11:0] SEVERITY_OFFSET = 12'h10C;
	localparam logic [11:0] COR_STATUS_OFFSET = 12'h110;

	// ----------------------------------------
	// Severity register layout
	// ----------------------------------------
	localparam int UNSUPPORTED_REQUEST_SEV = 20;
	localparam int END_TO_END_CRC_SEV = 19;
	localparam int MALFORMED_PACKET_SEV = 18;
	localparam int RECEIVER_OVERFLOW_SEV = 17;
	localparam int UNEXPECTED_COMPLETION_SEV = 16;
	localparam int COMPLETER_ABORT_SEV = 15;
	localparam int COMPLETION_TIMEOUT_SEV = 14;
	localparam int FLOW_CONTROL_SEV = 13;
	localparam int POISONED_PACKET_SEV = 12;
	localparam int LINK_PROTOCOL_SEV = 4;
	localparam logic [31:0] SEV_RW_MASK = 32'h001FF010;
	localparam logic [31:0] SEV_RO_ONES = 32'h00000021;
	localparam logic [31:0] SEV_RESET = 32'h00062011;

	// ----------------------------------------
	// Correctable status layout
	// ----------------------------------------
	localparam int ADVISORY_NONFATAL_FLAG = 13;
	localparam int REPLAY_TIMER_EXPIRED_FLAG = 12;
	localparam int REPLAY_ROLLOVER_FLAG = 8;
	localparam int LINK_PACKET_DECODE_FLAG = 7;
	localparam int TRANSACTION_PACKET_DECODE_FLAG = 6;
	localparam int RECEIVER_ERROR_FLAG = 0;
	localparam logic [31:0] COR_W1C_MASK = 32'h000031C1;
	localparam logic [31:0] COR_RESET = 32'h00000000;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} cfg_rsp_t;

	typedef struct packed {
		logic advisory_nonfatal;
		logic replay_timer_expired;
		logic replay_rollover;
		logic link_packet_decode;
		logic transaction_packet_decode;
		logic receiver_error;
	} cor_detect_t;

endpackage

// *** design/fundamental_reset_gen.sv ***
// Fundamental reset generator: asserts at once, releases synchronously
`timescale 1ns/100ps
module fundamental_reset_gen (
	// Clock
	input wire logic clk_in,
	// Reset pins, outside the clock domain
	input wire logic pcie_reset_n_in,
	input wire logic global_reset_n_in,
	// Combined reset
	output logic fundamental_reset_n_out
);

	logic pins_n;
	logic release_q1;

	// Either pin asserts the fundamental reset without waiting for a clock
	assign pins_n = pcie_reset_n_in & global_reset_n_in;

	// Two stages so release never lands near a clock edge
	always_ff @(posedge clk_in or negedge pins_n) begin
		if (!pins_n) begin
			release_q1 <= 1'b0;
			fundamental_reset_n_out <= 1'b0;
		end else begin
			release_q1 <= 1'b1;
			fundamental_reset_n_out <= release_q1;
		end
	end

endmodule

// *** design/aer_severity_status.sv ***
// Uncorrectable severity and correctable status registers with message steering
`timescale 1ns/100ps
module aer_severity_status (
	// Clock and resets
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic pcie_reset_n_in,
	input wire logic global_reset_n_in,
	// Configuration access
	input wire aer_regs_pkg::cfg_req_t cfg_req_in,
	output aer_regs_pkg::cfg_rsp_t cfg_rsp_out,
	// Error detection from the link and transaction logic
	input wire logic [31:0] unc_detect_in,
	input wire logic [31:0] unc_mask_in,
	input wire aer_regs_pkg::cor_detect_t cor_detect_in,
	input wire logic [31:0] cor_mask_in,
	// Message requests and register views
	output logic fatal_msg_out,
	output logic nonfatal_msg_out,
	output logic cor_msg_out,
	output logic [31:0] severity_out,
	output logic [31:0] cor_status_out,
	output logic fundamental_reset_n_out
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
		hit = (addr[11:2] == offset[11:2]);
	endfunction

	// ----------------------------------------
	// Fundamental reset
	// ----------------------------------------
	logic fundamental_reset_n;

	fundamental_reset_gen u_fundamental_reset (
		.clk_in(clk_in),
		.pcie_reset_n_in(pcie_reset_n_in),
		.global_reset_n_in(global_reset_n_in),
		.fundamental_reset_n_out(fundamental_reset_n)
	);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fundamental_reset_n_out <= 1'b0;
		end else begin
			fundamental_reset_n_out <= fundamental_reset_n;
		end
	end

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic sev_write;
	logic cor_write;
	logic [31:0] wr_lanes;
	logic [31:0] cor_clear;
	logic [31:0] cor_set;
	logic [31:0] cor_raw;
	logic [31:0] next_cor_status;
	logic [31:0] sev_read;

	assign wr_lanes = lane_mask(cfg_req_in.byte_en);
	assign sev_write = cfg_req_in.valid & cfg_req_in.write &
		hit(cfg_req_in.addr, aer_regs_pkg::SEVERITY_OFFSET);
	assign cor_write = cfg_req_in.valid & cfg_req_in.write &
		hit(cfg_req_in.addr, aer_regs_pkg::COR_STATUS_OFFSET);

	// ----------------------------------------
	// Severity register
	// ----------------------------------------
	logic [31:0] severity;

	// Footnoted bits only see the fundamental reset
	always_ff @(posedge clk_in or negedge fundamental_reset_n) begin
		if (!fundamental_reset_n) begin
			severity <= aer_regs_pkg::SEV_RESET & aer_regs_pkg::SEV_RW_MASK;
		end else if (sev_write) begin
			// Reserved positions never stored
			severity <= (severity & ~(wr_lanes & aer_regs_pkg::SEV_RW_MASK)) |
				(cfg_req_in.wdata & wr_lanes & aer_regs_pkg::SEV_RW_MASK);
		end
	end

	assign sev_read = severity | aer_regs_pkg::SEV_RO_ONES;

	// ----------------------------------------
	// Correctable status register
	// ----------------------------------------
	always_comb begin
		cor_raw = 32'h00000000;
		cor_raw[aer_regs_pkg::ADVISORY_NONFATAL_FLAG] = cor_detect_in.advisory_nonfatal;
		cor_raw[aer_regs_pkg::REPLAY_TIMER_EXPIRED_FLAG] =
			cor_detect_in.replay_timer_expired;
		cor_raw[aer_regs_pkg::REPLAY_ROLLOVER_FLAG] = cor_detect_in.replay_rollover;
		cor_raw[aer_regs_pkg::LINK_PACKET_DECODE_FLAG] = cor_detect_in.link_packet_decode;
		cor_raw[aer_regs_pkg::TRANSACTION_PACKET_DECODE_FLAG] =
			cor_detect_in.transaction_packet_decode;
		// Any decode error counts, whatever the packet type
		cor_raw[aer_regs_pkg::RECEIVER_ERROR_FLAG] = cor_detect_in.receiver_error |
			cor_detect_in.link_packet_decode |
			cor_detect_in.transaction_packet_decode;
	end

	assign cor_set = cor_raw & ~cor_mask_in & aer_regs_pkg::COR_W1C_MASK;
	assign cor_clear = cor_write ? (cfg_req_in.wdata & wr_lanes & aer_regs_pkg::COR_W1C_MASK) :
		32'h00000000;
	// Set after clear so a coincident event survives
	assign next_cor_status = (cor_status_out & ~cor_clear) | cor_set;

	// Sticky bits live in the fundamental reset domain
	logic [31:14] sticky_high;
	logic [12:0] sticky_low;
	logic advisory_status;

	always_ff @(posedge clk_in or negedge fundamental_reset_n) begin
		if (!fundamental_reset_n) begin
			sticky_high <= aer_regs_pkg::COR_RESET[31:14];
			sticky_low <= aer_regs_pkg::COR_RESET[12:0];
		end else begin
			sticky_high <= next_cor_status[31:14] &
				aer_regs_pkg::COR_W1C_MASK[31:14];
			sticky_low <= next_cor_status[12:0] & aer_regs_pkg::COR_W1C_MASK[12:0];
		end
	end

	// Advisory flag is not sticky, so only the ordinary reset clears it, not the fundamental reset
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			advisory_status <= aer_regs_pkg::COR_RESET[13];
		end else begin
			advisory_status <= next_cor_status[13];
		end
	end

	// Two reset domains, one driver per flop group, one view for readers
	assign cor_status_out = {sticky_high, advisory_status, sticky_low};

	// ----------------------------------------
	// Message steering
	// ----------------------------------------
	logic [31:0] unc_live;

	assign unc_live = unc_detect_in & ~unc_mask_in & aer_regs_pkg::SEV_RW_MASK;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fatal_msg_out <= 1'b0;
			nonfatal_msg_out <= 1'b0;
			cor_msg_out <= 1'b0;
			severity_out <= 32'h00000000;
		end else begin
			fatal_msg_out <= |(unc_live & severity);
			nonfatal_msg_out <= |(unc_live & ~severity);
			cor_msg_out <= |cor_set;
			severity_out <= sev_read;
		end
	end

	// ----------------------------------------
	// Configuration response
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg_rsp_out <= '0;
		end else begin
			cfg_rsp_out.ack <= cfg_req_in.valid;
			if (cfg_req_in.valid && !cfg_req_in.write) begin
				if (hit(cfg_req_in.addr, aer_regs_pkg::SEVERITY_OFFSET)) begin
					cfg_rsp_out.rdata <= sev_read;
				end else if (hit(cfg_req_in.addr, aer_regs_pkg::COR_STATUS_OFFSET)) begin
					cfg_rsp_out.rdata <= cor_status_out;
				end else begin
					cfg_rsp_out.rdata <= 32'h00000000;
				end
			end else begin
				cfg_rsp_out.rdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in || !fundamental_reset_n);

	localparam int REPLAY_BIT = aer_regs_pkg::REPLAY_TIMER_EXPIRED_FLAG;

	a_fatal_steer: assert property (
		|(unc_live & severity) |=> fatal_msg_out)
		else $error("fatal message missing for fatal class");
	a_nonfatal_steer: assert property (
		(unc_live != 32'h00000000) && ((unc_live & severity) == 32'h00000000)
		|=> nonfatal_msg_out && !fatal_msg_out)
		else $error("nonfatal class not sent as nonfatal");
	a_sev_fixed_bits: assert property (
		cfg_rsp_out.ack && $past(hit(cfg_req_in.addr, aer_regs_pkg::SEVERITY_OFFSET))
		&& $past(!cfg_req_in.write)
		|-> (cfg_rsp_out.rdata & ~aer_regs_pkg::SEV_RW_MASK) == aer_regs_pkg::SEV_RO_ONES)
		else $error("severity reserved bits read wrong");
	a_sev_write_takes: assert property (
		sev_write && (cfg_req_in.byte_en == 4'hF)
		|=> severity == ($past(cfg_req_in.wdata) & aer_regs_pkg::SEV_RW_MASK))
		else $error("severity write not stored");
	a_cor_reserved_zero: assert property (
		(cor_status_out & ~aer_regs_pkg::COR_W1C_MASK) == 32'h00000000)
		else $error("correctable reserved bit set");
	a_cor_sticky_hold: assert property (
		cor_status_out[REPLAY_BIT] && !(cor_write && cfg_req_in.wdata[REPLAY_BIT] &&
		cfg_req_in.byte_en[1]) |=> cor_status_out[REPLAY_BIT])
		else $error("sticky status bit lost");
	a_set_beats_clear: assert property (
		cor_set[REPLAY_BIT] |=> cor_status_out[REPLAY_BIT] [*2] or
		(cor_status_out[REPLAY_BIT] ##1 !cor_status_out[REPLAY_BIT]))
		else $error("event lost against clear");
	a_masked_quiet: assert property (
		cor_mask_in[REPLAY_BIT] && !cor_status_out[REPLAY_BIT]
		|=> !cor_status_out[REPLAY_BIT])
		else $error("masked class set status");
	a_decode_sets_both: assert property (
		cor_detect_in.link_packet_decode && !cor_mask_in[7] && !cor_mask_in[0]
		|=> cor_status_out[7] && cor_status_out[0])
		else $error("decode error not recorded");

	c_fatal_sent: cover property (fatal_msg_out);
	c_nonfatal_sent: cover property (nonfatal_msg_out);
	c_clear_status: cover property (cor_status_out[REPLAY_BIT] ##1 !cor_status_out[REPLAY_BIT]);
	c_coincident: cover property (cor_set[REPLAY_BIT] && cor_clear[REPLAY_BIT]);

endmodule

// *** testbench/cfg_host_model.sv ***
// Host configuration software model on the config request port
`timescale 1ns/100ps
module cfg_host_model (
	// Clock
	input wire logic clk_in,
	// Config access
	output aer_regs_pkg::cfg_req_t cfg_req_out,
	input wire aer_regs_pkg::cfg_rsp_t cfg_rsp_in
);
	initial cfg_req_out = '0;
	// ----
	// Access
	// ----
	// Valid for one edge only: the bank takes a request at every edge that sees it
	task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		cfg_req_out <= '{1'b1, wr, a, 4'hF, d};
		@(posedge clk_in);
		cfg_req_out <= '0;
		do begin
			@(posedge clk_in);
			n++;
		end while (cfg_rsp_in.ack !== 1'b1 && n < 8);
		q = cfg_rsp_in.rdata;
	endtask
endmodule

// *** testbench/aer_severity_status_tb.sv ***
// Self-checking bench for the severity and correctable status bank
`timescale 1ns/100ps
module aer_severity_status_tb;
	logic clk_in, rst_b_in, pcie_n, glob_n, fatal, nonfatal, cor_msg, fund_n;
	aer_regs_pkg::cfg_req_t cfg_req;
	aer_regs_pkg::cfg_rsp_t cfg_rsp;
	aer_regs_pkg::cor_detect_t cor_det;
	logic [31:0] unc_det, unc_mask, cor_mask, severity, cor_status, q, acc;
	logic [31:0] sev = 32'h000A5010;
	logic [31:0] cor_exp[6] = '{32'h1, 32'h41, 32'h81, 32'h100, 32'h1000, 32'h2000};
	int sev_pos[10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	localparam logic [11:0] SEV = aer_regs_pkg::SEVERITY_OFFSET;
	localparam logic [11:0] COR = aer_regs_pkg::COR_STATUS_OFFSET;

	aer_severity_status i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .pcie_reset_n_in(pcie_n),
		.global_reset_n_in(glob_n), .cfg_req_in(cfg_req), .cfg_rsp_out(cfg_rsp),
		.unc_detect_in(unc_det), .unc_mask_in(unc_mask), .cor_detect_in(cor_det),
		.cor_mask_in(cor_mask), .fatal_msg_out(fatal), .nonfatal_msg_out(nonfatal),
		.cor_msg_out(cor_msg), .severity_out(severity), .cor_status_out(cor_status),
		.fundamental_reset_n_out(fund_n));
	cfg_host_model i_host (.clk_in(clk_in), .cfg_req_out(cfg_req), .cfg_rsp_in(cfg_rsp));

	// ----
	// Tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (mismatches == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_host.access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		i_host.access(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask
	task automatic pulse_unc(input int p, input logic m);
		@(posedge clk_in);
		unc_mask <= {31'h0, m} << p;
		unc_det <= 32'h1 << p;
		@(posedge clk_in);
		unc_det <= '0;
		#1;
		check({30'h0, fatal, nonfatal}, m ? 32'h0 : {30'h0, sev[p], !sev[p]});
	endtask
	task automatic pulse_cor(input int i, input logic m, input logic [31:0] base);
		@(posedge clk_in);
		cor_mask <= m ? cor_exp[i] : 32'h0;
		cor_det <= 6'(1 << i);
		@(posedge clk_in);
		cor_det <= '0;
		#1;
		check(cor_status, m ? base : (base | cor_exp[i]));
		check({31'h0, cor_msg}, {31'h0, !m});
	endtask
	task automatic fund_reset_pulse(input logic which);
		@(posedge clk_in);
		if (which) pcie_n <= 1'b0;
		else glob_n <= 1'b0;
		repeat (2) @(posedge clk_in);
		pcie_n <= 1'b1;
		glob_n <= 1'b1;
		#1;
		check({31'h0, fund_n}, 32'h0);
		repeat (6) @(posedge clk_in);
	endtask

	// ----
	// Clock and watchdog
	// ----
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		forever begin
			@(posedge clk_in);
			cycles++;
			if (cycles >= 5000) begin
				mismatches++;
				test_done();
			end
		end
	end

	// ----
	// Sequence
	// ----
	initial begin
		{rst_b_in, pcie_n, glob_n} = 3'b000;
		{unc_det, unc_mask, cor_mask} = '0;
		cor_det = '0;
		repeat (3) @(posedge clk_in);
		{rst_b_in, pcie_n, glob_n} <= 3'b111;
		repeat (4) @(posedge clk_in);
		rd(SEV, 32'h00062031);
		rd(COR, 32'h0);
		rd(12'h100, 32'h0);
		wr(SEV, 32'hFFFFFFFF);
		rd(SEV, 32'h001FF031);
		wr(SEV, 32'h0);
		rd(SEV, 32'h00000021);
		wr(SEV, sev);
		for (int i = 0; i < 10; i++) pulse_unc(sev_pos[i], 1'b0);
		pulse_unc(18, 1'b1);
		for (int i = 0; i < 6; i++) begin
			pulse_cor(i, 1'b0, 32'h0);
			wr(COR, 32'h0);
			rd(COR, cor_exp[i]);
			wr(COR, cor_exp[i]);
			rd(COR, 32'h0);
		end
		pulse_cor(4, 1'b1, 32'h0);
		cor_mask <= '0;
		// Status builds up: each event adds its bits to what stands
		acc = 32'h0;
		for (int i = 0; i < 6; i++) begin
			pulse_cor(i, 1'b0, acc);
			acc = acc | cor_exp[i];
		end
		// Clear racing a fresh event must keep the event
		fork
			wr(COR, 32'h1000);
			begin
				@(posedge clk_in);
				cor_det <= 6'h10;
				@(posedge clk_in);
				cor_det <= '0;
				#1;
				check({31'h0, cor_status[12]}, 32'h1);
			end
		join
		@(posedge clk_in);
		cor_det <= 6'h3F;
		@(posedge clk_in);
		cor_det <= '0;
		wr(COR, 32'hFFFFCE3E);
		rd(COR, 32'h000031C1);
		wr(SEV, 32'h00100000);
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		rd(COR, 32'h000011C1);
		rd(SEV, 32'h00100021);
		fund_reset_pulse(1'b1);
		rd(SEV, 32'h00062031);
		rd(COR, 32'h0);
		wr(SEV, 32'h0);
		fund_reset_pulse(1'b0);
		rd(SEV, 32'h00062031);
		check(severity, 32'h00062031);
		test_done();
	end
endmodule
